// [hdl/io_cell_pkg.sv]
// constants, types and register map for the configurable i/o cell
//----------------------------------------------------------------------
// Functional notes
//----------------------------------------------------------------------
// Functional notes
// - global set/reset forces input register init value
// - flop loads on edge, latch passes; enable low holds
// - unconnected clock enable counts as high
// - single-tap: one delay, inserted by default
// - two-tap: full, partial or no delay
// - early capture latch runs on output clock
// - early capture feeds input register for resync
// - capture latch transparent low, then rising stage
// - every storage clock optionally inverted inside cell
// - early capture defaults delay to partial setting
// - output optionally inverted, direct or through flop
// - 3-state control high floats the pad
// - output and 3-state polarity configured independently
// - output flop init, hold, load; float on 3-state
// - unconnected 3-state control counts as low
// - each input path direct or registered
// - shared enable steers input, output or both
package io_cell_pkg;

    //------------------------------------------------------------------
    // register port
    //------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] CFG_ADDR  = 4'h0;
    localparam logic [ADDR_W-1:0] STAT_ADDR = 4'h4;

    //------------------------------------------------------------------
    // configuration register fields
    //------------------------------------------------------------------
    localparam int CFG_W            = 17;
    localparam int CFG_IN_LATCH     = 0;
    localparam int CFG_IN_SET       = 1;
    localparam int CFG_OUT_SET      = 2;
    localparam int CFG_DELAY_LO     = 3;
    localparam int CFG_EARLY_EN     = 5;
    localparam int CFG_ICLK_INV     = 6;
    localparam int CFG_OCLK_INV     = 7;
    localparam int CFG_OUT_INV      = 8;
    localparam int CFG_T_INV        = 9;
    localparam int CFG_OUT_REG      = 10;
    localparam int CFG_CE_TO_IN     = 11;
    localparam int CFG_CE_TO_OUT    = 12;
    localparam int CFG_CE_CONN      = 13;
    localparam int CFG_T_CONN       = 14;
    localparam int CFG_PATH1_REG    = 15;
    localparam int CFG_PATH2_REG    = 16;
    localparam logic [CFG_W-1:0] CFG_RESET = 17'h00018;

    //------------------------------------------------------------------
    // status register fields
    //------------------------------------------------------------------
    localparam int STAT_IN_Q    = 0;
    localparam int STAT_OUT_Q   = 1;
    localparam int STAT_EARLY_Q = 2;
    localparam int STAT_PAD     = 3;
    localparam int STAT_OE      = 4;

    // input delay selection; auto follows the early capture setting
    typedef enum logic [1:0] {
        DLY_FULL = 2'b00,
        DLY_PART = 2'b01,
        DLY_NONE = 2'b10,
        DLY_AUTO = 2'b11
    } delay_sel_e;

    //------------------------------------------------------------------
    // pin synchroniser bundle
    //------------------------------------------------------------------
    localparam int SYNC_W    = 3;
    localparam int SYNC_PAD  = 0;
    localparam int SYNC_ICLK = 1;
    localparam int SYNC_OCLK = 2;

    typedef struct packed {
        logic [SYNC_W-1:0] meta;
        logic [SYNC_W-1:0] held;
    } sync_s;

    // state of the cell, apart from the pin synchroniser flops held in pin_sync
    typedef struct packed {
        logic [CFG_W-1:0]  cfg;
        logic [DATA_W-1:0] rdata;
        logic              tap1;
        logic              tap2;
        logic              early;
        logic              in_q;
        logic              out_q;
        logic              iclk_prev;
        logic              oclk_prev;
        logic              pad_out;
        logic              pad_oe;
        logic              path1;
        logic              path2;
    } cell_s;

endpackage : io_cell_pkg

// [hdl/pin_sync.sv]
// two-stage synchroniser for the pad and the two cell clock pins
`timescale 1ns/10ps
module pin_sync (
    input  wire logic                           sys_clk,
    input  wire logic                           rst,
    input  wire logic [io_cell_pkg::SYNC_W-1:0] raw,
    output logic      [io_cell_pkg::SYNC_W-1:0] synced
);

    io_cell_pkg::sync_s st_q;
    io_cell_pkg::sync_s st_d;

    // first stage is read only by the second stage
    always_comb begin
        st_d      = st_q;
        st_d.meta = raw;
        st_d.held = st_q.meta;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign synced = st_q.held;

endmodule : pin_sync

// [hdl/io_cell.sv]
// storage and path logic of one configurable i/o cell
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/10ps
module io_cell #(
    parameter bit TWO_TAP = 1'b1
) (
    input  wire logic                           sys_clk,
    input  wire logic                           rst,
    input  wire logic                           global_set_reset,
    input  wire logic [io_cell_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [io_cell_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [io_cell_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                           pad_in,
    output logic                                pad_out,
    output logic                                pad_oe,
    input  wire logic                           input_clock_pin,
    input  wire logic                           output_clock_pin,
    input  wire logic                           shared_clock_enable,
    input  wire logic                           out_data,
    input  wire logic                           tristate_ctl,
    output logic                                input_path_one,
    output logic                                input_path_two
);

    //------------------------------------------------------------------
    // state and pin synchronisation
    //------------------------------------------------------------------
    io_cell_pkg::cell_s st_q;
    io_cell_pkg::cell_s st_d;

    logic [io_cell_pkg::SYNC_W-1:0] pins_raw;
    logic [io_cell_pkg::SYNC_W-1:0] pins_s;

    assign pins_raw = {output_clock_pin, input_clock_pin, pad_in};

    pin_sync u_pin_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .raw     (pins_raw),
        .synced  (pins_s)
    );

    //------------------------------------------------------------------
    // configuration fields
    //------------------------------------------------------------------
    logic       in_latch;
    logic       in_set;
    logic       out_set;
    logic [1:0] dly_raw;
    logic       early_en;
    logic       out_reg;
    logic       pad_s;

    assign in_latch = st_q.cfg[io_cell_pkg::CFG_IN_LATCH];
    assign in_set   = st_q.cfg[io_cell_pkg::CFG_IN_SET];
    assign out_set  = st_q.cfg[io_cell_pkg::CFG_OUT_SET];
    assign dly_raw  = st_q.cfg[io_cell_pkg::CFG_DELAY_LO +: 2];
    assign early_en = st_q.cfg[io_cell_pkg::CFG_EARLY_EN];
    assign out_reg  = st_q.cfg[io_cell_pkg::CFG_OUT_REG];
    assign pad_s    = pins_s[io_cell_pkg::SYNC_PAD];

    //------------------------------------------------------------------
    // clock polarity and edge detection
    //------------------------------------------------------------------
    logic iclk;
    logic oclk;
    logic irise;
    logic orise;

    // inversion sits inside the cell; toggling it can fake one edge
    assign iclk  = pins_s[io_cell_pkg::SYNC_ICLK] ^ st_q.cfg[io_cell_pkg::CFG_ICLK_INV];
    assign oclk  = pins_s[io_cell_pkg::SYNC_OCLK] ^ st_q.cfg[io_cell_pkg::CFG_OCLK_INV];
    assign irise = iclk & ~st_q.iclk_prev;
    assign orise = oclk & ~st_q.oclk_prev;

    //------------------------------------------------------------------
    // shared clock enable
    //------------------------------------------------------------------
    logic ce_eff;
    logic en_in;
    logic en_out;

    // a floating enable reads as high
    assign ce_eff = ~st_q.cfg[io_cell_pkg::CFG_CE_CONN] | shared_clock_enable;
    // an element not steered by the enable is always enabled
    assign en_in  = ce_eff | ~st_q.cfg[io_cell_pkg::CFG_CE_TO_IN];
    assign en_out = ce_eff | ~st_q.cfg[io_cell_pkg::CFG_CE_TO_OUT];

    //------------------------------------------------------------------
    // input delay selection
    //------------------------------------------------------------------
    logic [1:0] dly_sel;
    logic       full_tap;
    logic       delayed;
    logic       in_src;

    always_comb begin
        dly_sel = dly_raw;
        if (dly_raw == io_cell_pkg::DLY_AUTO) begin
            // early capture wants the partial delay unless chosen otherwise
            dly_sel = early_en ? io_cell_pkg::DLY_PART : io_cell_pkg::DLY_FULL;
        end
        if (!TWO_TAP && dly_sel == io_cell_pkg::DLY_PART) begin
            dly_sel = io_cell_pkg::DLY_FULL;
        end
    end

    // one tap in the single variant, two in the other
    assign full_tap = TWO_TAP ? st_q.tap2 : st_q.tap1;

    always_comb begin
        unique case (dly_sel)
            io_cell_pkg::DLY_FULL: delayed = full_tap;
            io_cell_pkg::DLY_PART: delayed = st_q.tap1;
            io_cell_pkg::DLY_NONE: delayed = pad_s;
            default:               delayed = full_tap;
        endcase
    end

    // the input register resynchronises the early capture result
    assign in_src = early_en ? st_q.early : delayed;

    //------------------------------------------------------------------
    // output polarity and 3-state control
    //------------------------------------------------------------------
    logic o_val;
    logic t_eff;

    assign o_val = out_data ^ st_q.cfg[io_cell_pkg::CFG_OUT_INV];
    // a floating 3-state control reads as low, so the pad is driven unless the 3-state inversion is set
    assign t_eff = (st_q.cfg[io_cell_pkg::CFG_T_CONN] & tristate_ctl)
                 ^ st_q.cfg[io_cell_pkg::CFG_T_INV];

    //------------------------------------------------------------------
    // next state
    //------------------------------------------------------------------
    always_comb begin
        st_d           = st_q;
        st_d.iclk_prev = iclk;
        st_d.oclk_prev = oclk;

        // delay taps, one system cycle each
        st_d.tap1 = pad_s;
        st_d.tap2 = st_q.tap1;

        // early capture latch follows data while output clock is low
        if (!oclk) begin
            st_d.early = delayed;
        end

        // input register: flop on rising edge, latch while clock high
        if (global_set_reset) begin
            st_d.in_q = in_set;
        end else if (en_in) begin
            if (in_latch ? iclk : irise) begin
                st_d.in_q = in_src;
            end
        end

        // output flop, always edge triggered on the output clock
        if (global_set_reset) begin
            st_d.out_q = out_set;
        end else if (en_out && orise) begin
            st_d.out_q = o_val;
        end

        // pad drive; a high 3-state control releases the pad
        st_d.pad_out = out_reg ? st_q.out_q : o_val;
        st_d.pad_oe  = ~t_eff;

        // the two paths into the array
        st_d.path1 = st_q.cfg[io_cell_pkg::CFG_PATH1_REG] ? st_q.in_q : pad_s;
        st_d.path2 = st_q.cfg[io_cell_pkg::CFG_PATH2_REG] ? st_q.in_q : pad_s;

        // register port: write config, read data valid one cycle later
        if (reg_wr && reg_addr == io_cell_pkg::CFG_ADDR) begin
            st_d.cfg = reg_wdata[io_cell_pkg::CFG_W-1:0];
        end
        st_d.rdata = '0;
        if (reg_rd) begin
            if (reg_addr == io_cell_pkg::CFG_ADDR) begin
                st_d.rdata[io_cell_pkg::CFG_W-1:0] = st_q.cfg;
            end else if (reg_addr == io_cell_pkg::STAT_ADDR) begin
                st_d.rdata[io_cell_pkg::STAT_IN_Q]    = st_q.in_q;
                st_d.rdata[io_cell_pkg::STAT_OUT_Q]   = st_q.out_q;
                st_d.rdata[io_cell_pkg::STAT_EARLY_Q] = st_q.early;
                st_d.rdata[io_cell_pkg::STAT_PAD]     = pad_s;
                st_d.rdata[io_cell_pkg::STAT_OE]      = st_q.pad_oe;
            end
        end
    end

    // power-up: reset values, config with both init bits clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q     <= '0;
            st_q.cfg <= io_cell_pkg::CFG_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    //------------------------------------------------------------------
    // outputs
    //------------------------------------------------------------------
    assign reg_rdata      = st_q.rdata;
    assign pad_out        = st_q.pad_out;
    assign pad_oe         = st_q.pad_oe;
    assign input_path_one = st_q.path1;
    assign input_path_two = st_q.path2;

endmodule : io_cell

// [verification/io_cell_properties.sv]
// port-level checks for the configurable i/o cell
`timescale 1ns/10ps
module io_cell_properties (
    input wire logic                           sys_clk,
    input wire logic                           rst,
    input wire logic                           global_set_reset,
    input wire logic [io_cell_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [io_cell_pkg::DATA_W-1:0] reg_wdata,
    input wire logic                           reg_wr,
    input wire logic                           reg_rd,
    input wire logic [io_cell_pkg::DATA_W-1:0] reg_rdata,
    input wire logic                           pad_out,
    input wire logic                           pad_oe,
    input wire logic                           shared_clock_enable,
    input wire logic                           out_data,
    input wire logic                           tristate_ctl,
    input wire logic                           input_path_one
);
    logic [io_cell_pkg::CFG_W-1:0] cfg_q;

    // shadow of the config word, so checks know the mode without peeking inside
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_q <= io_cell_pkg::CFG_RESET;
        end else if (reg_wr && reg_addr == io_cell_pkg::CFG_ADDR) begin
            cfg_q <= reg_wdata[io_cell_pkg::CFG_W-1:0];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // init held for two edges, mode bits untouched meanwhile
    sequence gsr_held;
        global_set_reset && $stable(cfg_q) ##1 global_set_reset && $stable(cfg_q);
    endsequence

    // first edge after reset still sees reset-time values, hence the past-reset guard
    oe_polarity_a: assert property (
        !$past(rst) |-> pad_oe == !(($past(tristate_ctl)
            & $past(cfg_q[io_cell_pkg::CFG_T_CONN])) ^ $past(cfg_q[io_cell_pkg::CFG_T_INV])))
        else $error("pad enable does not follow 3-state control");
    out_direct_a: assert property (
        !$past(rst) && !$past(cfg_q[io_cell_pkg::CFG_OUT_REG])
        |-> pad_out == ($past(out_data) ^ $past(cfg_q[io_cell_pkg::CFG_OUT_INV])))
        else $error("direct output value wrong");
    in_init_a: assert property (
        gsr_held ##0 cfg_q[io_cell_pkg::CFG_PATH1_REG]
        |=> input_path_one == $past(cfg_q[io_cell_pkg::CFG_IN_SET]))
        else $error("input register not at init value");
    out_init_a: assert property (
        gsr_held ##0 cfg_q[io_cell_pkg::CFG_OUT_REG]
        |=> pad_out == $past(cfg_q[io_cell_pkg::CFG_OUT_SET]))
        else $error("output flop not at init value");
    out_hold_a: assert property (
        (!shared_clock_enable && !global_set_reset && cfg_q[io_cell_pkg::CFG_CE_CONN] &&
         cfg_q[io_cell_pkg::CFG_CE_TO_OUT] && cfg_q[io_cell_pkg::CFG_OUT_REG])[*3]
        |-> $stable(pad_out)) else $error("output flop moved while disabled");
    cfg_readback_a: assert property (
        reg_rd && reg_addr == io_cell_pkg::CFG_ADDR |=> reg_rdata == {15'h0000, $past(cfg_q)})
        else $error("config readback wrong");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data not zero outside answer cycle");
    unmapped_read_a: assert property (reg_rd && reg_addr != io_cell_pkg::CFG_ADDR &&
        reg_addr != io_cell_pkg::STAT_ADDR |=> reg_rdata == 32'h00000000)
        else $error("unmapped read not zero");
    status_upper_a: assert property (reg_rd && reg_addr == io_cell_pkg::STAT_ADDR
        |=> reg_rdata[31:5] == 27'h0000000) else $error("status upper bits not zero");
endmodule : io_cell_properties

// [verification/pad_board.sv]
// board side of the pad: loopback of the driven level, pull-up when released
`timescale 1ns/10ps
module pad_board (
    input  wire logic pad_out,
    input  wire logic pad_oe,
    output logic      pad_in
);
    // pull-up makes a released open-drain pad read high, never a stale level
    assign pad_in = pad_oe ? pad_out : 1'b1;
endmodule : pad_board

// [verification/tb_top.sv]
// self-checking bench for the configurable i/o cell
`timescale 1ns/10ps
module tb_top;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        global_set_reset = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h00000000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata, rv;
    logic        pad_in, pad_out, pad_oe, input_path_one, input_path_two;
    logic        input_clock_pin = 1'b0;
    logic        output_clock_pin = 1'b0;
    logic        shared_clock_enable = 1'b0;
    logic        out_data = 1'b0;
    logic        tristate_ctl = 1'b1;
    int          mismatches = 0;
    int          n_checks = 0;
    int          lat [4];
    int          base;

    io_cell DUT (.sys_clk, .rst, .global_set_reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .pad_in, .pad_out, .pad_oe, .input_clock_pin, .output_clock_pin,
        .shared_clock_enable, .out_data, .tristate_ctl, .input_path_one, .input_path_two);
    pad_board board (.pad_out(pad_out), .pad_oe(pad_oe), .pad_in(pad_in));

    // 10 MHz system clock
    always #50 sys_clk = ~sys_clk;

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic cfg(input logic [31:0] c);
        wr(4'h0, c);
        step(8);
    endtask : cfg
    function automatic logic [31:0] b(input int pos);
        return 32'h00000001 << pos;
    endfunction : b
    // cell clock pins must sit at each level for at least two system cycles
    task automatic pulse(input bit outclk);
        @(posedge sys_clk);
        if (outclk) output_clock_pin <= 1'b1; else input_clock_pin <= 1'b1;
        step(4);
        if (outclk) output_clock_pin <= 1'b0; else input_clock_pin <= 1'b0;
        step(8);
    endtask : pulse
    task automatic drive(input logic d, input logic t, input logic ce);
        @(posedge sys_clk);
        out_data            <= d;
        tristate_ctl        <= t;
        shared_clock_enable <= ce;
        step(8);
    endtask : drive
    // latency from a pad change to the registered path, bounded wait
    task automatic lat_of(input logic v, output int n);
        n = 0;
        while (input_path_one !== v && n < 30) begin
            step(1);
            n++;
        end
        if (n == 30) begin
            chk("path wait", 32'h1, 32'h0);
            finish_test();
        end
    endtask : lat_of

    task automatic t_regs();
        rd(4'h0, rv);
        chk("cfg reset", 32'(io_cell_pkg::CFG_RESET), rv);
        chk("oe unconnected t", 32'h1, 32'(pad_oe));
        wr(4'h4, 32'hFFFFFFFF);
        wr(4'h0, 32'hFFFE0018);
        rd(4'h0, rv);
        chk("cfg upper ignored", 32'h00000018, rv);
        rd(4'h8, rv);
        chk("unmapped read", 32'h00000000, rv);
        rd(4'h4, rv);
        chk("status oe", 32'h1, 32'(rv[4]));
    endtask : t_regs
    task automatic t_polarity();
        for (int i = 0; i < 16; i++) begin
            drive(i[1], i[3], 1'b0);
            cfg(b(9) * i[0] | b(14) * i[1] | b(8) * i[2] | 32'h18);
            chk("pad enable", 32'(!((i[1] & i[3]) ^ i[0])), 32'(pad_oe));
            chk("pad value", 32'(i[1] ^ i[2]), 32'(pad_out));
        end
    endtask : t_polarity
    task automatic t_open_drain();
        cfg(b(14));
        for (int v = 0; v < 2; v++) begin
            drive(1'b0, v[0], 1'b0);
            chk("open drain pad", 32'(v[0]), 32'(input_path_two));
        end
    endtask : t_open_drain
    task automatic t_in_flop();
        cfg(b(15) | 32'h10);
        drive(1'b1, 1'b0, 1'b0);
        chk("direct path", 32'h1, 32'(input_path_two));
        pulse(1'b0);
        chk("flop load, ce unconnected", 32'h1, 32'(input_path_one));
        drive(1'b0, 1'b0, 1'b0);
        chk("flop hold", 32'h1, 32'(input_path_one));
        rd(4'h4, rv);
        chk("status in_q", 32'h1, 32'(rv[0]));
        chk("status pad", 32'h0, 32'(rv[3]));
        cfg(b(15) | 32'h10 | b(13) | b(11));
        pulse(1'b0);
        chk("input ce low", 32'h1, 32'(input_path_one));
        cfg(b(15) | 32'h10 | b(13) | b(12));
        pulse(1'b0);
        chk("ce steered to output", 32'h0, 32'(input_path_one));
    endtask : t_in_flop
    task automatic t_latch();
        cfg(b(15) | 32'h11);
        input_clock_pin <= 1'b1;
        drive(1'b1, 1'b0, 1'b1);
        chk("latch open", 32'h1, 32'(input_path_one));
        input_clock_pin <= 1'b0;
        drive(1'b0, 1'b0, 1'b1);
        chk("latch closed", 32'h1, 32'(input_path_one));
    endtask : t_latch
    task automatic t_delay();
        input_clock_pin <= 1'b1;
        for (int e = 0; e < 2; e++) begin
            for (int s = 0; s < 4; s++) begin
                cfg(b(15) | 32'h1 | 32'(s) << 3 | b(5) * e);
                drive(1'b0, 1'b0, 1'b1);
                @(posedge sys_clk);
                out_data <= 1'b1;
                #1 lat_of(1'b1, lat[s]);
            end
            if (e == 0) base = lat[2];
            chk("partial tap", 32'(lat[2] + 1), 32'(lat[1]));
            chk("full taps", 32'(lat[2] + 2), 32'(lat[0]));
            chk("auto delay", 32'(lat[e ? 1 : 0]), 32'(lat[3]));
        end
        chk("early stage", 32'(base + 1), 32'(lat[2]));
        output_clock_pin <= 1'b1;
        drive(1'b0, 1'b0, 1'b1);
        chk("early latch closed", 32'h1, 32'(input_path_one));
        rd(4'h4, rv);
        chk("status early", 32'h1, 32'(rv[2]));
        output_clock_pin <= 1'b0;
        step(8);
        chk("early latch open", 32'h0, 32'(input_path_one));
        input_clock_pin <= 1'b0;
    endtask : t_delay
    task automatic t_gsr_out();
        for (int j = 0; j < 4; j++) begin
            cfg(b(15) | b(10) | b(1) * j[0] | b(2) * j[1]);
            global_set_reset <= 1'b1;
            step(4);
            chk("input init", 32'(j[0]), 32'(input_path_one));
            chk("output init", 32'(j[1]), 32'(pad_out));
            global_set_reset <= 1'b0;
        end
        // invert the output clock, then clear the flop so the edges below tell
        cfg(b(7) | b(10));
        global_set_reset <= 1'b1;
        step(2);
        global_set_reset <= 1'b0;
        drive(1'b1, 1'b0, 1'b1);
        @(posedge sys_clk);
        output_clock_pin <= 1'b1;
        step(5);
        chk("inverted clock rise", 32'h0, 32'(pad_out));
        output_clock_pin <= 1'b0;
        step(5);
        chk("inverted clock fall", 32'h1, 32'(pad_out));
        cfg(b(7) | b(10) | b(13) | b(12));
        drive(1'b0, 1'b0, 1'b0);
        pulse(1'b1);
        chk("output ce low", 32'h1, 32'(pad_out));
        rd(4'h4, rv);
        chk("status out_q", 32'h1, 32'(rv[1]));
    endtask : t_gsr_out

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    // reset for twenty cycles, then every scenario in turn
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        step(2);
        t_regs();
        t_polarity();
        t_open_drain();
        t_in_flop();
        t_latch();
        t_delay();
        t_gsr_out();
        finish_test();
    end
endmodule : tb_top

bind io_cell io_cell_properties u_props (.sys_clk, .rst, .global_set_reset, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pad_out, .pad_oe, .shared_clock_enable,
    .out_data, .tristate_ctl, .input_path_one);
